// ==== common/rfs_pkg.sv ====
// shared constants of the remap fault status block
package rfs_pkg;
	localparam int          RFS_ADDR_W          = 12;
	localparam logic [11:0] RFS_OFF_STATUS      = 12'h034;
	localparam logic [11:0] RFS_OFF_EVT_CTL     = 12'h038;
	localparam logic [11:0] RFS_OFF_IRQ_STAT    = 12'h040;
	localparam logic [11:0] RFS_OFF_IRQ_CLR     = 12'h044;
	localparam logic [11:0] RFS_OFF_IRQ_EN      = 12'h048;
	localparam logic [11:0] RFS_OFF_MASK_CAP    = 12'h04C;
	localparam int          RFS_BIT_PPF         = 1;
	localparam int          RFS_BIT_QERR        = 4;
	localparam int          RFS_BIT_BADCPL      = 5;
	localparam int          RFS_BIT_TMO         = 6;
	localparam int          RFS_FRI_LO          = 8;
	localparam int          RFS_BIT_EVMASK      = 31;
	localparam int          RFS_PAGE_SHIFT      = 12;
	localparam int          RFS_MASK_W          = 6;
	localparam logic [5:0]  RFS_MASK_MAX_DEF    = 6'h09;
	localparam logic [31:0] RFS_STATUS_RST      = 32'h00000000;
	localparam logic        RFS_EVMASK_RST      = 1'b1;
	localparam logic [2:0]  RFS_IRQ_EN_RST      = 3'h0;
	localparam logic [1:0]  RFS_HTRANS_NONSEQ   = 2'h2;
endpackage

// ==== logic/rfs_sticky.sv ====
`timescale 1ns/10ps
// one sticky write-one-to-clear flag, set wins over clear
module rfs_sticky
	import rfs_pkg::*;
#(
	parameter bit PRESENT = 1'b1
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic ce,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag_q
);
	logic flag_d;

	// absent feature keeps the bit at zero
	assign flag_d = PRESENT & (set | (flag_q & ~clr));

	always_ff @(posedge clk) begin
		if (sys_rst)
			flag_q <= 1'b0;
		else if (ce)
			flag_q <= flag_d;
	end

	set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && set && PRESENT |=> flag_q) else $error("flag lost on set");
endmodule

// ==== logic/rfs_span_mask.sv ====
`timescale 1ns/10ps
// turns a page span mask value into an address mask above the page offset
module rfs_span_mask
	import rfs_pkg::*;
#(
	parameter int        ADDR_W   = 64,
	parameter logic [5:0] MASK_MAX = RFS_MASK_MAX_DEF
) (
	input  wire logic [5:0]        page_span_mask,
	output logic [ADDR_W-1:0]      addr_keep,
	output logic                   span_legal
);
	// ones from bit 12 upward except the low M page bits
	function automatic logic [ADDR_W-1:0] keep_bits(input logic [5:0] m);
		logic [ADDR_W-1:0] v;
		v = '1;
		v = v << (RFS_PAGE_SHIFT + int'(m));
		return v;
	endfunction

	assign addr_keep  = keep_bits(page_span_mask);
	assign span_legal = (page_span_mask <= MASK_MAX);
endmodule

// ==== logic/rfs_status.sv ====
`timescale 1ns/10ps
// fault status register bank with ahb-lite slave and fault event output

// Notes on behaviour
// - a span mask value M clears the low M page-number bits from bit 12 so 2^M pages match, 0 meaning one page.
// - when the pending-fault summary sets, the record pointer loads the index of the first pending record.
// - status bits 31:16 and bit 7 read zero and ignore writes.
// - bit 6 sets when a device-TLB invalidation completion times out.
// - bit 5 sets on an unexpected or invalid device-TLB invalidation completion.
// - bit 4 sets on an invalidation queue error.
// - setting any of the three error flags may raise a fault event per the event control register.
// - without device-TLB support bits 6 and 5 are reserved zero.
// - without queued invalidation support bit 4 is reserved zero.
// - error flags hold until software writes one to them; writing zero does nothing.
// - the pending-fault summary is the OR of all record fault flags.
// - while the event mask bit is set, which it is after reset, no fault event is sent.
module rfs_status
	import rfs_pkg::*;
#(
	parameter int         NUM_REC     = 8,
	parameter bit         HAS_DEVTLB  = 1'b1,
	parameter bit         HAS_QINV    = 1'b1,
	parameter int         ADDR_W      = 64,
	parameter logic [5:0] MASK_MAX    = RFS_MASK_MAX_DEF
) (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               ce,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic [NUM_REC-1:0] rec_fault,
	input  wire logic               cpl_timeout,
	input  wire logic               cpl_bad,
	input  wire logic               queue_err,
	input  wire logic [5:0]         page_span_mask,
	output logic [ADDR_W-1:0]       addr_keep,
	output logic                    span_legal,
	output logic                    fault_event,
	output logic                    irq
);
	// index of lowest set record flag
	function automatic logic [7:0] first_set(input logic [NUM_REC-1:0] v);
		logic [7:0] idx;
		idx = 8'h00;
		for (int i = NUM_REC - 1; i >= 0; i--) begin
			if (v[i])
				idx = 8'(i);
		end
		return idx;
	endfunction

	logic        wr_pend_q;
	logic [11:0] wr_addr_q;
	logic        ppf_q;
	logic [7:0]  fri_q;
	logic [7:0]  fri_d;
	logic        evmask_q;
	logic [2:0]  irq_en_q;
	logic        tmo_q;
	logic        bad_q;
	logic        qerr_q;
	logic        ppf_d;
	logic        ppf_rise;
	logic        err_rise;
	logic        addr_ok;
	logic        rd_go;
	logic [31:0] rd_mux;
	logic        wr_status;
	logic        wr_evctl;
	logic        wr_irqclr;
	logic        wr_irqen;
	logic [2:0]  err_vec;
	logic [2:0]  clr_vec;
	logic [31:0] status_word;

	// address phase decode; single wait-free transfers
	assign addr_ok   = ce & hsel & hready & (htrans == RFS_HTRANS_NONSEQ);
	assign rd_go     = addr_ok & ~hwrite;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// write data arrives one cycle after the address phase
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end else if (ce) begin
			wr_pend_q <= addr_ok & hwrite;
			wr_addr_q <= haddr[11:0];
		end
	end

	assign wr_status = ce & wr_pend_q & (wr_addr_q == RFS_OFF_STATUS);
	assign wr_evctl  = ce & wr_pend_q & (wr_addr_q == RFS_OFF_EVT_CTL);
	assign wr_irqclr = ce & wr_pend_q & (wr_addr_q == RFS_OFF_IRQ_CLR);
	assign wr_irqen  = ce & wr_pend_q & (wr_addr_q == RFS_OFF_IRQ_EN);

	// write-one clears from the status word or the clear register
	assign clr_vec[0] = (wr_status & hwdata[RFS_BIT_QERR]) | (wr_irqclr & hwdata[0]);
	assign clr_vec[1] = (wr_status & hwdata[RFS_BIT_BADCPL]) | (wr_irqclr & hwdata[1]);
	assign clr_vec[2] = (wr_status & hwdata[RFS_BIT_TMO]) | (wr_irqclr & hwdata[2]);

	rfs_sticky #(.PRESENT(HAS_QINV)) u_qerr (
		.clk    (clk),
		.sys_rst(sys_rst),
		.ce     (ce),
		.set    (queue_err),
		.clr    (clr_vec[0]),
		.flag_q (qerr_q)
	);

	rfs_sticky #(.PRESENT(HAS_DEVTLB)) u_bad (
		.clk    (clk),
		.sys_rst(sys_rst),
		.ce     (ce),
		.set    (cpl_bad),
		.clr    (clr_vec[1]),
		.flag_q (bad_q)
	);

	rfs_sticky #(.PRESENT(HAS_DEVTLB)) u_tmo (
		.clk    (clk),
		.sys_rst(sys_rst),
		.ce     (ce),
		.set    (cpl_timeout),
		.clr    (clr_vec[2]),
		.flag_q (tmo_q)
	);

	rfs_span_mask #(.ADDR_W(ADDR_W), .MASK_MAX(MASK_MAX)) u_span (
		.page_span_mask(page_span_mask),
		.addr_keep     (addr_keep),
		.span_legal    (span_legal)
	);

	// summary tracks the record flags; pointer loads only as summary rises
	assign ppf_d    = |rec_fault;
	assign ppf_rise = ppf_d & ~ppf_q;
	assign fri_d    = ppf_rise ? first_set(rec_fault) : fri_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ppf_q <= 1'b0;
			fri_q <= 8'h00;
		end else if (ce) begin
			ppf_q <= ppf_d;
			fri_q <= fri_d;
		end
	end

	// event mask resets set so nothing leaves until software opens it
	always_ff @(posedge clk) begin
		if (sys_rst)
			evmask_q <= RFS_EVMASK_RST;
		else if (wr_evctl)
			evmask_q <= hwdata[RFS_BIT_EVMASK];
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			irq_en_q <= RFS_IRQ_EN_RST;
		else if (wr_irqen)
			irq_en_q <= hwdata[2:0];
	end

	assign err_vec = {tmo_q, bad_q, qerr_q};

	// a new error or summary rise is the fault event; pulse output
	assign err_rise = (queue_err & HAS_QINV & ~qerr_q) | (cpl_bad & HAS_DEVTLB & ~bad_q)
		| (cpl_timeout & HAS_DEVTLB & ~tmo_q);

	always_ff @(posedge clk) begin
		if (sys_rst)
			fault_event <= 1'b0;
		else if (ce)
			fault_event <= (err_rise | ppf_rise) & ~evmask_q;
	end

	assign irq = |(err_vec & irq_en_q);

	// reserved bits 31:16 and 7 stay zero in the assembled word
	assign status_word = {16'h0000, fri_q, 1'b0, tmo_q, bad_q, qerr_q, 2'b00, ppf_q, 1'b0};

	always_comb begin
		unique case (haddr[11:0])
			RFS_OFF_STATUS:   rd_mux = status_word;
			RFS_OFF_EVT_CTL:  rd_mux = {evmask_q, 31'h00000000};
			RFS_OFF_IRQ_STAT: rd_mux = {29'h00000000, err_vec};
			RFS_OFF_IRQ_EN:   rd_mux = {29'h00000000, irq_en_q};
			RFS_OFF_MASK_CAP: rd_mux = {26'h0000000, MASK_MAX};
			default:          rd_mux = 32'h00000000;
		endcase
	end

	// read data registered for the data phase
	always_ff @(posedge clk) begin
		if (sys_rst)
			hrdata <= 32'h00000000;
		else if (rd_go)
			hrdata <= rd_mux;
	end

	// named steps shared by the checks below; a read is judged by the data it loads, not by a stale address
	sequence status_read_s;
		rd_go && haddr[11:0] == RFS_OFF_STATUS;
	endsequence

	sequence tmo_clear_s;
		ce && clr_vec[2] && !cpl_timeout;
	endsequence

	sequence bad_clear_s;
		ce && clr_vec[1] && !cpl_bad;
	endsequence

	sequence qerr_clear_s;
		ce && clr_vec[0] && !queue_err;
	endsequence

	sequence evctl_write_s;
		wr_evctl;
	endsequence

	sequence ptr_quiet_s;
		ce && !ppf_rise;
	endsequence

	// read data of the status word: reserved zeros and the pointer as it stood at the address phase
	rsvd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		status_read_s |=> hrdata[31:16] == 16'h0000 && hrdata[7] == 1'b0)
		else $error("reserved status bits not zero");
	ptr_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		status_read_s |=> hrdata[15:8] == $past(fri_q))
		else $error("pointer read back wrong");

	// flags set on their event and clear when a one is written; the hold check covers only the timeout flag
	tmo_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && cpl_timeout && HAS_DEVTLB |=> tmo_q)
		else $error("timeout flag not set");
	bad_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && cpl_bad && HAS_DEVTLB |=> bad_q)
		else $error("completion flag not set");
	qerr_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && queue_err && HAS_QINV |=> qerr_q)
		else $error("queue flag not set");
	sticky_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && tmo_q && !clr_vec[2] |=> tmo_q)
		else $error("timeout flag dropped");
	tmo_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		tmo_clear_s |=> !tmo_q)
		else $error("timeout flag not cleared");
	bad_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		bad_clear_s |=> !bad_q)
		else $error("completion flag not cleared");
	qerr_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		qerr_clear_s |=> !qerr_q)
		else $error("queue flag not cleared");
	devtlb_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		!HAS_DEVTLB |-> !tmo_q && !bad_q)
		else $error("absent flags set");
	qinv_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		!HAS_QINV |-> !qerr_q)
		else $error("absent queue flag set");

	// summary follows the records; the pointer moves only when the summary rises
	summary_or_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> ppf_q == $past(|rec_fault))
		else $error("summary not or of records");
	ptr_load_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && ppf_rise |=> fri_q == $past(first_set(rec_fault)))
		else $error("pointer not loaded");
	ptr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		ptr_quiet_s |=> fri_q == $past(fri_q))
		else $error("pointer moved without a rise");

	// event path; a frozen cycle keeps the last pulse, so the mask check looks at live cycles only
	mask_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		evctl_write_s |=> evmask_q == $past(hwdata[RFS_BIT_EVMASK]))
		else $error("event mask not written");
	mask_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(ce) && $past(evmask_q) |-> !fault_event)
		else $error("event sent while masked");
	event_raise_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && err_rise && !evmask_q |=> fault_event)
		else $error("event missing");
	event_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(ce) && fault_event |-> $past(err_rise || ppf_rise))
		else $error("event without a cause");

	// span decode: mask 0 keeps bit 12 and clears the page offset
	span_one_a: assert property (@(posedge clk) disable iff (sys_rst)
		page_span_mask == 6'h00 |-> addr_keep[RFS_PAGE_SHIFT] && addr_keep[RFS_PAGE_SHIFT-1:0] == 12'h000)
		else $error("mask 0 hides a page");
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the remap fault status block over its ahb-lite port
`timescale 1ns/10ps
module tb_top
	import rfs_pkg::*;
;
	logic        clk;
	logic        sys_rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [2:0]  hsize;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  rec_fault;
	logic [2:0]  ev;
	logic [5:0]  page_span_mask;
	logic [63:0] addr_keep;
	logic        span_legal;
	logic        fault_event;
	logic        irq;
	int          n_errors;
	int          check_count;
	int          n_ev;

	// ce held high: state is never frozen in this bench
	rfs_status i_rfs_status (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rec_fault(rec_fault),
		.cpl_timeout(ev[2]), .cpl_bad(ev[1]), .queue_err(ev[0]), .page_span_mask(page_span_mask),
		.addr_keep(addr_keep), .span_legal(span_legal), .fault_event(fault_event), .irq(irq));

	// clock of 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// event pulses counted as they leave the block
	always @(posedge clk) begin
		if (sys_rst)
			n_ev <= 0;
		else if (fault_event === 1'b1)
			n_ev <= n_ev + 1;
	end

	task automatic tally_and_finish;
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// bounded wait so a stuck slave cannot hang the run
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 16) begin
				n_errors++;
				tally_and_finish();
			end
			@(posedge clk);
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= RFS_HTRANS_NONSEQ;
		hwrite <= w;
		hsize  <= 3'h2;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		r = hrdata;
		check({63'h0, hresp}, 64'h0);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] msk, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h00000000, r);
		check({32'h00000000, r & msk}, {32'h00000000, exp});
	endtask

	task automatic pulse(input logic [2:0] v);
		ev <= v;
		@(posedge clk);
		ev <= 3'h0;
		repeat (3) @(posedge clk);
	endtask

	// the level output settles after the edge that applied the write, so look one edge later
	task automatic check_irq(input logic exp);
		@(posedge clk);
		check({63'h0, irq}, {63'h0, exp});
	endtask

	initial begin
		n_errors = 0;
		check_count = 0;
		sys_rst = 1'b1;
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		rec_fault = 8'h00;
		ev = 3'h0;
		page_span_mask = 6'h00;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		// reset values, capability, unmapped place
		rd(32'h00000034, 32'hFFFFFFFF, 32'h00000000);
		rd(32'h00000038, 32'hFFFFFFFF, 32'h80000000);
		rd(32'h0000004C, 32'hFFFFFFFF, 32'h00000009);
		rd(32'h00000100, 32'hFFFFFFFF, 32'h00000000);
		// all three error sources while the event is masked
		pulse(3'h7);
		rd(32'h00000034, 32'hFFFFFFFF, 32'h00000070);
		rd(32'h00000040, 32'hFFFFFFFF, 32'h00000007);
		check(n_ev, 0);
		// reserved and read-only bits ignore writes, zeros leave flags alone
		wr(32'h00000034, 32'hFFFFFF8F);
		rd(32'h00000034, 32'hFFFFFFFF, 32'h00000070);
		wr(32'h00000034, 32'h00000020);
		rd(32'h00000034, 32'hFFFFFFFF, 32'h00000050);
		// level interrupt: enable, clear, mask
		wr(32'h00000048, 32'h00000001);
		check_irq(1'b1);
		wr(32'h00000044, 32'h00000001);
		check_irq(1'b0);
		pulse(3'h1);
		check_irq(1'b1);
		wr(32'h00000048, 32'h00000000);
		check_irq(1'b0);
		wr(32'h00000034, 32'h00000070);
		rd(32'h00000034, 32'hFFFFFFFF, 32'h00000000);
		// unmasked: a newly set flag raises one fault event
		wr(32'h00000038, 32'h00000000);
		rd(32'h00000038, 32'hFFFFFFFF, 32'h00000000);
		pulse(3'h2);
		check(n_ev, 1);
		wr(32'h00000034, 32'h00000020);
		// summary and first record pointer
		rec_fault <= 8'h28;
		pulse(3'h0);
		rd(32'h00000034, 32'hFFFFFFFF, 32'h00000302);
		check(n_ev, 2);
		rec_fault <= 8'h00;
		pulse(3'h0);
		rd(32'h00000034, 32'hFFFF00FF, 32'h00000000);
		rec_fault <= 8'h80;
		pulse(3'h0);
		rd(32'h00000034, 32'hFFFFFFFF, 32'h00000702);
		check(n_ev, 3);
		// span mask: one page for 0, legal up to the capability value
		for (int m = 0; m < 16; m++) begin
			@(posedge clk);
			page_span_mask <= 6'(m);
			@(negedge clk);
			check(addr_keep, ~((64'h1 << (RFS_PAGE_SHIFT + m)) - 64'h1));
			check({63'h0, span_legal}, {63'h0, m <= RFS_MASK_MAX_DEF});
		end
		// a 2MB mapping asks for mask 9: bits 20:12 masked, bit 21 still compared
		@(posedge clk);
		page_span_mask <= 6'h09;
		@(negedge clk);
		check({43'h0, addr_keep[20:0]}, 64'h0);
		check({63'h0, addr_keep[21]}, 64'h1);
		tally_and_finish();
	end
endmodule
